/* inc/mesb_pkg.sv */
// Constants for the monitor error status bank: offsets, bit classes, reset values.
// Assumes the flags are packed register by register, 40h in bits 7:0.
package mesb_pkg;

  localparam int unsigned NUM_REGS  = 4;
  localparam int unsigned REG_WIDTH = 8;
  localparam int unsigned NUM_FLAGS = NUM_REGS * REG_WIDTH;

  localparam logic [7:0] REG_OFS_TEMP_REG_ERR   = 8'h40;
  localparam logic [7:0] REG_OFS_VOLT_LOW_ERR   = 8'h41;
  localparam logic [7:0] REG_OFS_VOLT_HIGH_ERR  = 8'h42;
  localparam logic [7:0] REG_OFS_DIODE_CORE_ERR = 8'h43;

  localparam logic [7:0] REG_RESET_VALUE = 8'h00;
  localparam logic [7:0] READ_UNMAPPED   = 8'h00;

  // Bit positions inside 40h
  localparam int unsigned BIT_ZONE_ONE   = 0;
  localparam int unsigned BIT_ZONE_TWO   = 1;
  localparam int unsigned BIT_ZONE_THREE = 2;
  localparam int unsigned BIT_ZONE_FOUR  = 3;
  localparam int unsigned BIT_REG_ONE    = 4;
  localparam int unsigned BIT_REG_TWO    = 5;

  // Bit positions inside 43h
  localparam int unsigned BIT_DIODE_ONE_B = 0;
  localparam int unsigned BIT_DIODE_TWO_B = 1;
  localparam int unsigned BIT_FUSE_EIGHT  = 2;
  localparam int unsigned BIT_FUSE_NINE   = 3;
  localparam int unsigned BIT_CORE_ONE    = 4;
  localparam int unsigned BIT_CORE_TWO    = 5;
  localparam int unsigned BIT_DIODE_ONE_A = 6;
  localparam int unsigned BIT_DIODE_TWO_A = 7;

  // Sleep classes, flag vector order {43h, 42h, 41h, 40h}
  localparam logic [31:0] ALWAYS_MASKED   = 32'h3c47ff30;
  localparam logic [31:0] OPTIONAL_MASKED = 32'hc3380003;
  localparam logic [31:0] RESERVED_BITS   = 32'h000000c0;

  typedef enum logic [1:0] {
    MESB_S0   = 2'b00,
    MESB_S1   = 2'b01,
    MESB_S3   = 2'b11,
    MESB_S4_5 = 2'b10
  } mesb_sleep_t;

endpackage

/* inc/mesb_flag_if.sv */
// Carrier between the status bank top and its sticky flag array.
// Assumes both ends share one clock.
`timescale 1ns/1ps
interface mesb_flag_if #(
  parameter int unsigned WIDTH = 32
);
  logic [WIDTH-1:0] raise;
  logic [WIDTH-1:0] clear;
  logic [WIDTH-1:0] flag;

  modport owner (input raise, input clear, output flag);
  modport user  (output raise, output clear, input flag);
endinterface

/* verilog/mesb_sticky_bank.sv */
// Array of sticky flags: set by a level, cleared by a pulse, set wins.
// Assumes clear and raise are synchronous to clk.
`timescale 1ns/1ps
module mesb_sticky_bank #(
  parameter int unsigned WIDTH = 32
) (
  input  wire logic   clk,
  input  wire logic   rst_b,
  mesb_flag_if.owner  bus
);

  logic [WIDTH-1:0] flag_q;
  logic [WIDTH-1:0] flag_d;

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      // A persisting event re-sets in the clearing cycle
      always_comb begin
        flag_d[i] = bus.raise[i] | (flag_q[i] & ~bus.clear[i]); // R12
      end

      always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
          flag_q[i] <= 1'b0;
        end else begin
          flag_q[i] <= flag_d[i];
        end
      end
    end
  endgenerate

  assign bus.flag = flag_q;

endmodule

/* verilog/mesb_status_bank.sv */
// Top of the four sticky error status registers at 40h..43h.
// Assumes an upstream two-wire slave turns bus cycles into byte read/write strobes.
// What this block does
// R1 - Zone one and two limit events set 40h bits 0 and 1, optionally sleep masked.
// R2 - Zone three and four events set 40h bits 2 and 3, never masked.
// R3 - Regulator hot inputs set 40h bits 4 and 5, always masked in S3, S4/5.
// R4 - Analog inputs 1 to 8 set 41h bits, always masked in S3, S4/5.
// R5 - Analog inputs 9 to 16 set 42h; 9, 10, 11, 15 always sleep masked.
// R6 - Analog inputs 12 to 14 are optionally masked per sleep mask settings.
// R7 - Analog input 16 flag is never masked by sleep.
// R8 - Diode channel b faults set 43h bits 0 and 1, optionally masked.
// R9 - Diode channel a faults set 43h bits 6 and 7, optionally masked.
// R10 - Fuse inputs set 43h bits 2 and 3 only in version 10 coding.
// R11 - Core voltage mismatches on inputs 7 and 8 set 43h bits 4 and 5.
// R12 - Flags stick until cleared; clear fails while an unmasked error persists.
// R13 - Alert-standard mode clears on read and write one, else write one only.
// R14 - Any set flag raises the controller error summary and, if enabled, alert.
// R15 - Reported sleep state and sleep mask settings gate optional class flags.
// R16 - Reserved 40h bits 7 and 6 read zero and ignore writes.
`timescale 1ns/1ps
module mesb_status_bank (
  input  wire logic        clk,
  input  wire logic        rst_b,
  // Byte register port
  input  wire logic [7:0]  regAddr,
  input  wire logic        regWrite,
  input  wire logic [7:0]  regWdata,
  input  wire logic        regRead,
  output logic      [7:0]  regRdata,
  output logic             regRvalid,
  output logic             regHit,
  // Error event levels
  input  wire logic [1:0]  zoneLowLimitEvent,
  input  wire logic [1:0]  zoneHighLimitEvent,
  input  wire logic [1:0]  zoneThreeFourLimitEvent,
  input  wire logic        regulatorOneHotInput,
  input  wire logic        regulatorTwoHotInput_b,
  input  wire logic [15:0] analogLimitEvent,
  input  wire logic        diodeOneAFault,
  input  wire logic        diodeOneBFault,
  input  wire logic        diodeTwoAFault,
  input  wire logic        diodeTwoBFault,
  input  wire logic        fuseSenseInputEight,
  input  wire logic        fuseSenseInputNine,
  input  wire logic        versionTenCoding,
  input  wire logic        coreOneVoltageMismatch,
  input  wire logic        coreTwoVoltageMismatch,
  // Configuration held elsewhere in the monitor
  input  wire logic [1:0]  sleepState,
  input  wire logic [31:0] sleepMaskS3,
  input  wire logic [31:0] sleepMaskS45,
  input  wire logic        alertStandardMode,
  input  wire logic        alertEnable,
  // Summary and alert pin
  output logic             controllerErrorSummary,
  output logic             alertOut,
  output logic             alertOe_b
);

  localparam int unsigned NF = mesb_pkg::NUM_FLAGS;

  mesb_flag_if #(.WIDTH(NF)) flagBus ();

  mesb_sticky_bank #(
    .WIDTH (NF)
  ) u_bank (
    .clk   (clk),
    .rst_b (rst_b),
    .bus   (flagBus.owner)
  );

  logic [NF-1:0] rawEvent;
  logic [NF-1:0] sleepMask;
  logic [NF-1:0] clearVec;
  logic          inSleep;
  logic          rdTaken;
  logic          addrHit;
  logic [1:0]    regIdx;
  logic [7:0]    regOffset;
  logic [7:0]    readByte;

  logic [7:0]    rdata_q;
  logic [7:0]    rdata_d;
  logic          rvalid_q;
  logic          rvalid_d;
  logic          hit_q;
  logic          hit_d;
  logic          summary_q;
  logic          summary_d;
  logic          alertOe_b_q;
  logic          alertOe_b_d;

  // Event assembly and sleep gating
  always_comb begin
    rawEvent = '0;
    // Zone one and two cover several readings each
    rawEvent[mesb_pkg::BIT_ZONE_ONE]   = zoneLowLimitEvent[0] | zoneHighLimitEvent[0]; // R1
    rawEvent[mesb_pkg::BIT_ZONE_TWO]   = zoneLowLimitEvent[1] | zoneHighLimitEvent[1]; // R1
    rawEvent[mesb_pkg::BIT_ZONE_THREE] = zoneThreeFourLimitEvent[0]; // R2
    rawEvent[mesb_pkg::BIT_ZONE_FOUR]  = zoneThreeFourLimitEvent[1]; // R2
    rawEvent[mesb_pkg::BIT_REG_ONE]    = regulatorOneHotInput; // R3
    rawEvent[mesb_pkg::BIT_REG_TWO]    = ~regulatorTwoHotInput_b; // R3
    rawEvent[15:8]  = analogLimitEvent[7:0]; // R4
    rawEvent[23:16] = analogLimitEvent[15:8]; // R5
    rawEvent[24 + mesb_pkg::BIT_DIODE_ONE_B] = diodeOneBFault; // R8
    rawEvent[24 + mesb_pkg::BIT_DIODE_TWO_B] = diodeTwoBFault; // R8
    rawEvent[24 + mesb_pkg::BIT_FUSE_EIGHT]  = fuseSenseInputEight & versionTenCoding; // R10
    rawEvent[24 + mesb_pkg::BIT_FUSE_NINE]   = fuseSenseInputNine & versionTenCoding; // R10
    // Both compared against processor one's requested code upstream
    rawEvent[24 + mesb_pkg::BIT_CORE_ONE]    = coreOneVoltageMismatch; // R11
    rawEvent[24 + mesb_pkg::BIT_CORE_TWO]    = coreTwoVoltageMismatch; // R11
    rawEvent[24 + mesb_pkg::BIT_DIODE_ONE_A] = diodeOneAFault; // R9
    rawEvent[24 + mesb_pkg::BIT_DIODE_TWO_A] = diodeTwoAFault; // R9
    rawEvent = rawEvent & ~mesb_pkg::RESERVED_BITS; // R16

    inSleep = (sleepState == mesb_pkg::MESB_S3) || (sleepState == mesb_pkg::MESB_S4_5); // R15
    if (!inSleep) begin
      sleepMask = '0; // R2 R7
    end else if (sleepState == mesb_pkg::MESB_S3) begin
      sleepMask = mesb_pkg::ALWAYS_MASKED | (mesb_pkg::OPTIONAL_MASKED & sleepMaskS3); // R3 R4 R5 R6 R15
    end else begin
      sleepMask = mesb_pkg::ALWAYS_MASKED | (mesb_pkg::OPTIONAL_MASKED & sleepMaskS45); // R3 R4 R5 R6 R15
    end
  end

  // Register decode, clearing and read data
  always_comb begin
    // Write wins when both strobes meet, so no read is answered then
    rdTaken   = regRead && !regWrite;
    regOffset = regAddr - mesb_pkg::REG_OFS_TEMP_REG_ERR;
    addrHit   = (regAddr >= mesb_pkg::REG_OFS_TEMP_REG_ERR) &&
                (regAddr <= mesb_pkg::REG_OFS_DIODE_CORE_ERR);
    regIdx    = regOffset[1:0];
    clearVec  = '0;
    readByte  = mesb_pkg::READ_UNMAPPED;
    if (addrHit) begin
      readByte = flagBus.flag[regIdx*8 +: 8];
      if (regWrite) begin
        clearVec[regIdx*8 +: 8] = regWdata; // R13
      end else if (regRead && alertStandardMode) begin
        // Data is captured at the same edge the flags drop
        clearVec[regIdx*8 +: 8] = 8'hff; // R13
      end
    end
    clearVec = clearVec & ~mesb_pkg::RESERVED_BITS; // R16

    rdata_d     = rdTaken ? readByte : rdata_q;
    rvalid_d    = rdTaken;
    hit_d       = rdTaken ? addrHit : hit_q;
    summary_d   = |flagBus.flag; // R14
    alertOe_b_d = ~(summary_q & alertEnable); // R14
  end

  assign flagBus.raise = rawEvent & ~sleepMask; // R12
  assign flagBus.clear = clearVec;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rdata_q     <= mesb_pkg::REG_RESET_VALUE;
      rvalid_q    <= 1'b0;
      hit_q       <= 1'b0;
      summary_q   <= 1'b0;
      alertOe_b_q <= 1'b1;
    end else begin
      rdata_q     <= rdata_d;
      rvalid_q    <= rvalid_d;
      hit_q       <= hit_d;
      summary_q   <= summary_d;
      alertOe_b_q <= alertOe_b_d;
    end
  end

  assign regRdata               = rdata_q;
  assign regRvalid              = rvalid_q;
  assign regHit                 = hit_q;
  assign controllerErrorSummary = summary_q;
  // Open drain: only ever pulls low
  assign alertOut               = 1'b0;
  assign alertOe_b              = alertOe_b_q;

endmodule

/* verilog/README_unused.sv */
// Holds no logic; the bank is the top module and its sticky flag array.

/* verification/mesb_status_bank_sva.sv */
// Port checker for the error status bank.
// Assumes it is bound onto mesb_status_bank with matching port names.
`timescale 1ns/1ps
module mesb_status_bank_sva (
  input wire logic        clk,
  input wire logic        rst_b,
  input wire logic [7:0]  regAddr,
  input wire logic        regWrite,
  input wire logic        regRead,
  input wire logic [7:0]  regRdata,
  input wire logic        regRvalid,
  input wire logic        regHit,
  input wire logic [15:0] analogLimitEvent,
  input wire logic [1:0]  sleepState,
  input wire logic        alertEnable,
  input wire logic        controllerErrorSummary,
  input wire logic        alertOe_b
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  // A write in the same cycle wins, so that read is not taken
  wire rdGo = regRead && !regWrite;
  wire alertOn = controllerErrorSummary && alertEnable;
  read_answer_a: assert property (rdGo |=> regRvalid) else $error("no read answer");
  stray_valid_a: assert property (!rdGo |=> !regRvalid) else $error("stray valid");
  reserved_zero_a: assert property (rdGo && regAddr == 8'h40 |=> regRdata[7:6] == 2'b00)
    else $error("reserved bits set");
  unmapped_read_a: assert property (rdGo && regAddr[7:2] != 6'h10 |=> regRdata == 8'h00 && !regHit)
    else $error("unmapped read");
  sticky_summary_a: assert property (controllerErrorSummary && !$past(regWrite)
    && !$past(regRead) |=> controllerErrorSummary) else $error("flag lost");
  analog_sets_a: assert property (!sleepState[1] && analogLimitEvent != 16'h0000
    |-> ##2 controllerErrorSummary) else $error("analog event lost");
  input16_open_a: assert property (analogLimitEvent[15] |-> ##2 controllerErrorSummary)
    else $error("input 16 masked");
  alert_follow_a: assert property (alertOn |=> !alertOe_b) else $error("alert not driven");
  alert_idle_a: assert property (!alertOn |=> alertOe_b) else $error("alert driven idle");
endmodule

/* verification/mesb_bmc_model.sv */
// Management controller model: single byte reads and writes.
// Assumes the bank answers a read with regRvalid one cycle later.
`timescale 1ns/1ps
module mesb_bmc_model (
  input  wire logic       clk,
  input  wire logic [7:0] regRdata,
  input  wire logic       regRvalid,
  output logic      [7:0] regAddr,
  output logic            regWrite,
  output logic      [7:0] regWdata,
  output logic            regRead
);
  initial {regAddr, regWrite, regWdata, regRead} = '0;
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    regAddr <= a;
    regWdata <= d;
    regWrite <= 1'b1;
    @(negedge clk);
    regWrite <= 1'b0;
    // Released lines must not keep looking valid
    regAddr <= ~a;
    regWdata <= ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    int n;
    @(negedge clk);
    regAddr <= a;
    regRead <= 1'b1;
    @(negedge clk);
    regRead <= 1'b0;
    regAddr <= ~a;
    for (n = 0; n < 8 && regRvalid !== 1'b1; n++) @(negedge clk);
    d = (regRvalid === 1'b1) ? regRdata : 8'hxx;
  endtask
endmodule

/* verification/mesb_status_bank_test.sv */
// Self-checking bench for the monitor error status bank.
// Assumes one register request per clock and event levels driven at falling edges.
`timescale 1ns/1ps
module mesb_status_bank_test;
  logic clk, rst_b, regWrite, regRead, regRvalid, regHit;
  logic [7:0] regAddr, regWdata, regRdata, got;
  logic [1:0] zoneLowLimitEvent, zoneHighLimitEvent, zoneThreeFourLimitEvent, sleepState;
  logic [15:0] analogLimitEvent;
  logic [31:0] sleepMaskS3, sleepMaskS45;
  logic regulatorOneHotInput, regulatorTwoHotInput_b, diodeOneAFault, diodeOneBFault;
  logic diodeTwoAFault, diodeTwoBFault, fuseSenseInputEight, fuseSenseInputNine;
  logic versionTenCoding, coreOneVoltageMismatch, coreTwoVoltageMismatch, alertStandardMode;
  logic alertEnable, controllerErrorSummary, alertOut, alertOe_b;
  int nErrors, numChecks;
  mesb_status_bank dut (.*);
  mesb_bmc_model bmc (.*);
  task automatic chk(input string s, input logic [7:0] seen, input logic [7:0] exp);
    numChecks++;
    if (seen !== exp) begin
      nErrors++;
      $display("ERROR %s expected %h seen %h", s, exp, seen);
    end
  endtask
  task automatic regs(input logic [31:0] exp);
    for (int i = 0; i < 4; i++) begin
      bmc.rd(8'h40 + 8'(i), got);
      chk("status", got, exp[8*i +: 8]);
    end
  endtask
  task automatic clrAll();
    for (int i = 0; i < 4; i++) bmc.wr(8'h40 + 8'(i), 8'hff);
  endtask
  task automatic calm();
    {zoneLowLimitEvent, zoneHighLimitEvent, analogLimitEvent, regulatorOneHotInput} = '0;
    {diodeOneAFault, diodeOneBFault, diodeTwoAFault, diodeTwoBFault} = '0;
    {fuseSenseInputEight, fuseSenseInputNine, coreOneVoltageMismatch} = '0;
    coreTwoVoltageMismatch = 1'b0;
    zoneThreeFourLimitEvent = 2'b00;
    regulatorTwoHotInput_b = 1'b1;
  endtask
  // One cycle of every event (zone one by its low limit, zone two by its high limit), analog pattern chosen by caller
  task automatic storm(input logic [15:0] an);
    @(negedge clk);
    {zoneLowLimitEvent, zoneHighLimitEvent, zoneThreeFourLimitEvent} = 6'b011011;
    analogLimitEvent = an;
    {regulatorOneHotInput, regulatorTwoHotInput_b, diodeOneAFault, diodeOneBFault} = 4'hb;
    {diodeTwoAFault, diodeTwoBFault, fuseSenseInputEight, fuseSenseInputNine} = 4'hf;
    {coreOneVoltageMismatch, coreTwoVoltageMismatch} = 2'b11;
    @(negedge clk);
    calm();
  endtask
  task automatic tMap();
    regs(32'h0);
    bmc.rd(8'h44, got);
    chk("unmapped", {got[7:1], got[0] | regHit}, 8'h00);
    storm(16'h8421);
    regs(32'hff84213f);
    regs(32'hff84213f);
    clrAll();
    regs(32'h0);
    versionTenCoding = 1'b0;
    storm(16'h0000);
    regs(32'hf300003f);
    clrAll();
    versionTenCoding = 1'b1;
  endtask
  task automatic tPersist();
    analogLimitEvent = 16'h0001;
    bmc.wr(8'h41, 8'h01);
    regs(32'h00000100);
    sleepState = 2'b01;
    bmc.wr(8'h41, 8'h01);
    regs(32'h00000100);
    sleepState = 2'b11;
    bmc.wr(8'h41, 8'h01);
    regs(32'h0);
    sleepState = 2'b00;
    calm();
  endtask
  task automatic tSleep();
    sleepMaskS3 = 32'h40100001;
    sleepState = 2'b11;
    storm(16'hffff);
    regs(32'h83a8000e);
    clrAll();
    sleepState = 2'b10;
    storm(16'hffff);
    regs(32'h0080000c);
    clrAll();
    sleepState = 2'b00;
  endtask
  task automatic tAsfAlert();
    alertStandardMode = 1'b1;
    alertEnable = 1'b1;
    storm(16'h0002);
    repeat (2) @(negedge clk);
    chk("alert on", 8'({controllerErrorSummary, alertOut, alertOe_b}), 8'h04);
    bmc.rd(8'h41, got);
    chk("asf first", got, 8'h02);
    bmc.rd(8'h41, got);
    chk("asf again", got, 8'h00);
    clrAll();
    repeat (3) @(negedge clk);
    chk("alert off", 8'({controllerErrorSummary, alertOut, alertOe_b}), 8'h01);
  endtask
  task automatic close_out();
    $display("checks %0d errors %0d", numChecks, nErrors);
    if (nErrors == 0 && numChecks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  initial begin
    rst_b = 1'b0;
    {sleepState, alertStandardMode, alertEnable, sleepMaskS3} = '0;
    sleepMaskS45 = '1;
    versionTenCoding = 1'b1;
    calm();
    repeat (4) @(negedge clk);
    rst_b = 1'b1;
    tMap();
    tPersist();
    tSleep();
    tAsfAlert();
    close_out();
  end
  initial begin
    #20000;
    nErrors++;
    close_out();
  end
endmodule
bind mesb_status_bank mesb_status_bank_sva chk (.*);
